// ==== dv/dds_host_model.sv ====
// host controller model: drives select lines and measures output pulses
`default_nettype none
module dds_host_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // selection request from the bench
  input  wire logic       en_i,
  input  wire logic       binary_i,
  input  wire logic [2:0] unit_i,
  output logic      [3:0] select_n_o,
  // active low outputs watched for pulses
  input  wire logic [4:0] mon_n_i,
  output var int          width_o [5],
  output var int          falls_o [5]
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q [5];

  // binary: line 0 enables, lines 3..1 carry the inverted unit code
  assign select_n_o = binary_i ? {~unit_i, ~en_i} :
                      ~({3'b000, en_i} << unit_i[1:0]);

  // host never writes, so no read falls in the post-write settle time
  // low time of each pulse is counted in clocks, logged when it ends
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 5; i++) begin
      if (rst_i) begin
        cnt_q[i]   <= 0;
        width_o[i] <= 0;
        falls_o[i] <= 0;
      end else if (mon_n_i[i] == 1'b0) begin
        cnt_q[i] <= cnt_q[i] + 1;
      end else if (cnt_q[i] != 0) begin
        width_o[i] <= cnt_q[i];
        falls_o[i] <= falls_o[i] + 1;
        cnt_q[i]   <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// testbench for the disk drive status output block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dds_pkg::*;
  localparam int RC = 50;
  localparam int IL = 60;
  localparam int IS = 20;
  localparam int SC = 20;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [3:0]  adr = 0, sel_n, bsel = 4'hf;
  logic [31:0] wdat = 0, rdat, rd;
  logic        pwr = 0, spd = 0, med = 0, prt = 0, trk = 0, dsm = 0;
  logic        sd1_n = 1, hld_n = 1, en = 0, bin = 0, ack, winh;
  logic [2:0]  unit = 0;
  logic [4:0]  ev = 0;
  logic        rdy_n, prt_n, trk_n, idx_n, sec_n, raw_n, sd_n, sc_n, unc_n, two_n;
  int          wid [5], fl [5];
  int          failures = 0, checked = 0, f0;

  dds_drive_status #(.READY_CYC(RC), .INDEX_LONG_CYC(IL), .INDEX_SHORT_CYC(IS),
    .SECTOR_CYC(SC)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rd),
    .wb_ack_o(ack), .select_n_i(sel_n), .power_ok_i(pwr), .speed_ok_i(spd),
    .media_present_i(med), .media_protected_i(prt), .heads_at_outer_i(trk),
    .index_hole_i(ev[0]), .sector_hole_i(ev[1]), .flux_reversal_i(ev[2]),
    .data_transition_i(ev[3]), .clock_transition_i(ev[4]),
    .double_sided_media_i(dsm), .side1_select_n_i(sd1_n),
    .head_load_command_n_i(hld_n), .ready_n_o(rdy_n),
    .media_protect_status_n_o(prt_n), .track_zero_n_o(trk_n), .index_n_o(idx_n),
    .sector_n_o(sec_n), .raw_data_n_o(raw_n), .separated_data_pulse_n_o(sd_n),
    .separated_clock_pulse_n_o(sc_n), .uncertified_side_n_o(unc_n),
    .two_sided_n_o(two_n), .write_inhibit_o(winh));

  dds_host_model host (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .binary_i(bin),
    .unit_i(unit), .select_n_o(sel_n), .mon_n_i({sc_n, sd_n, sec_n, idx_n, raw_n}),
    .width_o(wid), .falls_o(fl));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rdat = rd;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_i);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // sensor event: high 4 clocks, then low for w clocks
  task automatic ev_pulse(input int b, input int w);
    ev[b] <= 1'b1;
    wt(4);
    ev[b] <= 1'b0;
    wt(w);
  endtask

  initial begin
    wt(20000);
    failures++;
    end_of_test;
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    wt(8);
    rst_i <= 0;
    wt(1);
    check("idle", {rdy_n, prt_n, trk_n, idx_n, sec_n, raw_n, sd_n, sc_n, unc_n, two_n,
      winh}, 11'h7fe);
    bus(0, ADR_CTRL, 0); check("ctrl_reset", rdat, CTRL_RST);
    bus(0, 4'h8, 0); check("unmapped", rdat, 32'h0);
    bus(1, ADR_CTRL, 32'h80);
    pwr <= 1; spd <= 1; med <= 1;
    wt(30); check("ready_wait", rdy_n, 1'b1);
    wt(40); check("ready_on", rdy_n, 1'b0);
    spd <= 0; wt(8); check("ready_slow", rdy_n, 1'b1);
    spd <= 1;
    bus(1, ADR_CTRL, 32'h0);
    en <= 1; prt <= 1; trk <= 1; wt(8);
    check("protect", prt_n, 1'b0);
    check("inhibit", winh, 1'b1);
    check("track0", trk_n, 1'b0);
    en <= 0; wt(8);
    check("unsel", {prt_n, trk_n, winh}, 3'b111);
    bus(1, ADR_CTRL, 32'h540);
    bin <= 1; unit <= 5; en <= 1; wt(8);
    check("bin_own", trk_n, 1'b0);
    unit <= 4; wt(8); check("bin_other", trk_n, 1'b1);
    unit <= 5; en <= 0; wt(8); check("bin_off", trk_n, 1'b1);
    bin <= 0; unit <= 0; en <= 1; prt <= 0; trk <= 0;
    bus(1, ADR_CTRL, 32'h0);
    f0 = fl[3] + fl[4];
    ev_pulse(2, 50); check("raw_width", wid[0], RAW_CYC);
    ev_pulse(3, 50);
    ev_pulse(4, 50); check("sep_off", fl[3] + fl[4], f0);
    bus(1, ADR_CTRL, 32'h8);
    f0 = fl[0];
    ev_pulse(2, 50); check("raw_count", fl[0], f0 + 1);
    ev_pulse(3, 50); check("sepd_width", wid[3], SEP_CYC);
    ev_pulse(4, 50); check("sepc_width", wid[4], SEP_CYC);
    en <= 0; wt(8);
    f0 = fl[0];
    ev_pulse(2, 50); check("raw_unsel", fl[0], f0);
    f0 = fl[1];
    ev_pulse(0, 70); check("idx_unsel", fl[1], f0);
    en <= 1;
    bus(1, ADR_CTRL, 32'h0);
    ev_pulse(0, 70); check("index_long", wid[1], IL);
    for (int d = 0; d < 3; d++) begin
      bus(1, ADR_CTRL, 32'h1 | (d << 1));
      ev_pulse(0, 30); check("index_short", wid[1], IS);
      f0 = fl[2];
      repeat (8) ev_pulse(1, 25);
      check("sector_count", fl[2] - f0, 8 >> d);
    end
    check("sector_width", wid[2], SC);
    bus(1, ADR_CTRL, 32'h10);
    sd1_n <= 0; wt(8); check("uncert", unc_n, 1'b0);
    bus(1, ADR_CTRL, 32'h30);
    bus(0, ADR_CTRL, 0); check("opt_excl", rdat, 32'h10);
    bsel <= 4'h2;
    bus(1, ADR_CTRL, 32'h7ef);
    bsel <= 4'hf;
    bus(0, ADR_CTRL, 0); check("lane_mask", rdat, 32'h710);
    bus(1, ADR_CTRL, 32'h20);
    dsm <= 1; hld_n <= 0; wt(8); check("two_side", two_n, 1'b0);
    hld_n <= 1; wt(8); check("two_unload", two_n, 1'b1);
    hld_n <= 0; dsm <= 0; wt(8); check("two_single", two_n, 1'b1);
    bus(0, ADR_STAT, 0); check("status", rdat, 32'h163);
    end_of_test;
  end
endmodule
`default_nettype wire

// ==== rtl/dds_drive_status.sv ====
// flexible disk drive status and timing outputs with wishbone control
//
// Summary of operation
// RULE1 - ready low only with power and speed
// RULE2 - ready follows power nominally two seconds later
// RULE3 - protected media inhibits writes, status when selected
// RULE4 - track zero status shown only when selected
// RULE5 - one revolution mark pulse per revolution
// RULE6 - hard segment option shortens revolution mark
// RULE7 - hard segment option gives segment hole pulses
// RULE8 - reduced division passes every second/fourth hole
// RULE9 - one flux pulse per flux reversal
// RULE10 - flux pulse lasts fixed 200 ns
// RULE11 - separated outputs driven only with separator option
// RULE12 - separated data pulse per data transition
// RULE13 - uncertified side flag on single-sided side one
// RULE14 - double sided flag with media and heads loaded
// RULE15 - double sided flag off when unloaded or single
// RULE16 - the two side flag options are exclusive
// RULE17 - controller waits 50 us after write
// RULE18 - radial mode drives status without select
// RULE19 - binary code addresses one of eight drives
// RULE20 - first select line enables, three carry code
// RULE21 - unselected: outputs off, inputs ignored but select; write_inhibit_o still follows media protect
// RULE22 - all timing from reset-cleared clock counters
//
// The Wishbone register port and the register addresses were left to the implementer.
`default_nettype none
module dds_drive_status #(
  parameter int unsigned READY_CYC       = dds_pkg::READY_CYC,
  parameter int unsigned INDEX_LONG_CYC  = dds_pkg::INDEX_LONG_CYC,
  parameter int unsigned INDEX_SHORT_CYC = dds_pkg::INDEX_SHORT_CYC,
  parameter int unsigned SECTOR_CYC      = dds_pkg::SECTOR_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // interface select lines, active low
  input  wire logic [3:0]  select_n_i,
  // mechanism sensors
  input  wire logic        power_ok_i,
  input  wire logic        speed_ok_i,
  input  wire logic        media_present_i,
  input  wire logic        media_protected_i,
  input  wire logic        heads_at_outer_i,
  input  wire logic        index_hole_i,
  input  wire logic        sector_hole_i,
  input  wire logic        flux_reversal_i,
  input  wire logic        data_transition_i,
  input  wire logic        clock_transition_i,
  input  wire logic        double_sided_media_i,
  input  wire logic        side1_select_n_i,
  input  wire logic        head_load_command_n_i,
  // status outputs, active low except write_inhibit_o, which is active high
  output logic             ready_n_o,
  output logic             media_protect_status_n_o,
  output logic             track_zero_n_o,
  output logic             index_n_o,
  output logic             sector_n_o,
  output logic             raw_data_n_o,
  output logic             separated_data_pulse_n_o,
  output logic             separated_clock_pulse_n_o,
  output logic             uncertified_side_n_o,
  output logic             two_sided_n_o,
  output logic             write_inhibit_o
);
  import dds_pkg::*;

  if (INDEX_SHORT_CYC == 0 || INDEX_SHORT_CYC >= INDEX_LONG_CYC ||
      SECTOR_CYC == 0 || READY_CYC == 0) begin : g_bad_param
    $error("dds_drive_status: timing parameters out of range");
  end

  // ------------------------------------------------------------
  // shared counter step
  // ------------------------------------------------------------
  function automatic logic [31:0] dds_step(input logic        start,
                                           input logic [31:0] len,
                                           input logic [31:0] cnt);
    if (start) begin
      return len;
    end
    return (cnt != 32'h0) ? cnt - 32'h1 : 32'h0;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] pins;
  assign pins = {head_load_command_n_i, side1_select_n_i, double_sided_media_i,
                 clock_transition_i, data_transition_i, flux_reversal_i,
                 sector_hole_i, index_hole_i, heads_at_outer_i,
                 media_protected_i, media_present_i, speed_ok_i, power_ok_i,
                 select_n_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic [NIN-1:0] rise;
  assign rise = s2_q & ~s3_q;

  // ------------------------------------------------------------
  // control register and wishbone slave
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        req;
  logic [31:0] status;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wb_sel_i[0]) begin
      ctrl_d[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      ctrl_d[10:8] = wb_dat_i[10:8];
    end
    if (ctrl_d[CB_ILL]) begin
      ctrl_d[CB_DS] = 1'b0; // [RULE16]
    end
    if (ctrl_d[CB_DIV +: 2] == 2'b11) begin
      ctrl_d[CB_DIV +: 2] = DIV8;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (ack_q && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ADR_CTRL) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= req;
      rdat_q <= 32'h0;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          ADR_CTRL: rdat_q <= ctrl_q;
          ADR_STAT: rdat_q <= status;
          default:  rdat_q <= 32'h0;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  logic       hard;
  logic       sep_en;
  logic       ill_en;
  logic       ds_en;
  logic       bin_mode;
  logic       radial;
  logic [2:0] unit;
  dds_div_t   div;
  assign hard     = ctrl_q[CB_HARD];
  assign sep_en   = ctrl_q[CB_SEP];
  assign ill_en   = ctrl_q[CB_ILL];
  assign ds_en    = ctrl_q[CB_DS];
  assign bin_mode = ctrl_q[CB_BIN];
  assign radial   = ctrl_q[CB_RAD];
  assign unit     = ctrl_q[CB_UNIT +: 3];
  assign div      = dds_div_t'(ctrl_q[CB_DIV +: 2]);

  // ------------------------------------------------------------
  // unit selection
  // ------------------------------------------------------------
  logic [3:0] sel_act;
  logic       selected;
  logic       stat_en;
  assign sel_act = ~s2_q[3:0];
  always_comb begin
    if (bin_mode) begin
      selected = sel_act[0] && (sel_act[3:1] == unit); // [RULE19] [RULE20]
    end else begin
      selected = sel_act[unit[1:0]];
    end
  end
  assign stat_en = selected || radial; // [RULE18]

  logic head_load_command;
  logic side1;
  assign head_load_command  = selected && !s2_q[P_HLD]; // [RULE21]
  assign side1 = selected && !s2_q[P_SD1];

  // ------------------------------------------------------------
  // ready sequencing
  // ------------------------------------------------------------
  dds_rdy_t    rdy_q;
  logic [31:0] rdy_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_q     <= RDY_OFF;
      rdy_cnt_q <= 32'h0;
    end else if (!s2_q[P_PWR]) begin
      rdy_q     <= RDY_OFF;
      rdy_cnt_q <= 32'h0;
    end else begin
      case (rdy_q)
        RDY_OFF: begin
          rdy_q     <= RDY_WAIT;
          rdy_cnt_q <= READY_CYC - 32'h1; // [RULE2] [RULE22]
        end
        RDY_WAIT: begin
          if (rdy_cnt_q == 32'h0) begin
            rdy_q <= RDY_ON;
          end else begin
            rdy_cnt_q <= rdy_cnt_q - 32'h1;
          end
        end
        RDY_ON:  rdy_q <= RDY_ON;
        default: rdy_q <= RDY_OFF;
      endcase
    end
  end
  logic ready;
  assign ready = (rdy_q == RDY_ON) && s2_q[P_PWR] && s2_q[P_SPD]
                 && s2_q[P_MED]; // [RULE1]

  // ------------------------------------------------------------
  // pulse counters
  // ------------------------------------------------------------
  logic [31:0] idx_cnt_q;
  logic [31:0] sec_cnt_q;
  logic [31:0] raw_cnt_q;
  logic [31:0] sd_cnt_q;
  logic [31:0] sc_cnt_q;
  logic [1:0]  hole_q;
  logic        sec_take;
  logic [31:0] idx_len;
  assign idx_len = hard ? INDEX_SHORT_CYC : INDEX_LONG_CYC; // [RULE6]

  always_comb begin
    case (div)
      DIV16:   sec_take = (hole_q[0] == 1'b0); // [RULE8]
      DIV8:    sec_take = (hole_q == 2'b00);   // [RULE8]
      default: sec_take = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hole_q <= 2'b00;
    end else if (rise[P_IDX]) begin
      hole_q <= 2'b00;
    end else if (rise[P_SEC]) begin
      hole_q <= hole_q + 2'b01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_cnt_q <= 32'h0; // [RULE22]
      sec_cnt_q <= 32'h0;
      raw_cnt_q <= 32'h0;
      sd_cnt_q  <= 32'h0;
      sc_cnt_q  <= 32'h0;
    end else begin
      idx_cnt_q <= dds_step(rise[P_IDX], idx_len, idx_cnt_q); // [RULE5]
      sec_cnt_q <= dds_step(rise[P_SEC] && hard && sec_take,
                            SECTOR_CYC, sec_cnt_q); // [RULE7]
      raw_cnt_q <= dds_step(rise[P_FLX], RAW_CYC, raw_cnt_q); // [RULE9] [RULE10]
      sd_cnt_q  <= dds_step(rise[P_DTR] && sep_en, SEP_CYC, sd_cnt_q); // [RULE12]
      sc_cnt_q  <= dds_step(rise[P_CTR] && sep_en, SEP_CYC, sc_cnt_q);
    end
  end

  // ------------------------------------------------------------
  // output flops
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_n_o                 <= 1'b1;
      media_protect_status_n_o  <= 1'b1;
      track_zero_n_o            <= 1'b1;
      index_n_o                 <= 1'b1;
      sector_n_o                <= 1'b1;
      raw_data_n_o              <= 1'b1;
      separated_data_pulse_n_o  <= 1'b1;
      separated_clock_pulse_n_o <= 1'b1;
      uncertified_side_n_o      <= 1'b1;
      two_sided_n_o             <= 1'b1;
      write_inhibit_o           <= 1'b0;
    end else begin
      ready_n_o                <= !(ready && stat_en);
      media_protect_status_n_o <= !(selected && s2_q[P_PRT]); // [RULE3]
      track_zero_n_o           <= !(selected && s2_q[P_TRK]); // [RULE4]
      index_n_o                <= !(stat_en && idx_cnt_q != 32'h0);
      sector_n_o               <= !(stat_en && hard && sec_cnt_q != 32'h0);
      raw_data_n_o             <= !(selected && raw_cnt_q != 32'h0); // [RULE21]
      separated_data_pulse_n_o <= !(selected && sep_en
                                    && sd_cnt_q != 32'h0); // [RULE11]
      separated_clock_pulse_n_o <= !(selected && sep_en
                                     && sc_cnt_q != 32'h0); // [RULE11]
      uncertified_side_n_o <= !(ill_en && side1 && s2_q[P_MED]
                                && !s2_q[P_DSM]); // [RULE13]
      two_sided_n_o <= !(ds_en && head_load_command && s2_q[P_MED]
                         && s2_q[P_DSM]); // [RULE14] [RULE15]
      write_inhibit_o <= s2_q[P_PRT]; // [RULE3]
    end
  end

  assign status = {21'h0, hole_q, rdy_q, selected, head_load_command,
                   s2_q[P_DSM], s2_q[P_TRK], s2_q[P_PRT], s2_q[P_MED], ready};

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence flux_seen_s;
    rise[P_FLX] && selected;
  endsequence
  sequence stay_sel_s;
    selected ##1 selected;
  endsequence

  ready_gate_a: assert property ( // [RULE1]
    !ready_n_o |-> $past(s2_q[P_PWR] && s2_q[P_SPD] && stat_en))
    else $error("ready asserted without power, speed or select");
  protect_sel_a: assert property ( // [RULE3]
    !media_protect_status_n_o |-> $past(selected && s2_q[P_PRT]))
    else $error("protect status shown while unselected");
  track_sel_a: assert property ( // [RULE4]
    $past(!selected) |-> track_zero_n_o)
    else $error("track zero shown while unselected");
  index_len_a: assert property ( // [RULE5] [RULE6]
    rise[P_IDX] |=> idx_cnt_q == (hard ? INDEX_SHORT_CYC : INDEX_LONG_CYC))
    else $error("revolution mark width wrong");
  sector_off_a: assert property ( // [RULE7]
    !$past(hard) |-> sector_n_o)
    else $error("segment pulse without hard segment option");
  sector_skip_a: assert property ( // [RULE8]
    rise[P_SEC] && !sec_take && sec_cnt_q == 32'h0 |=> sec_cnt_q == 32'h0)
    else $error("skipped hole produced a segment pulse");
  flux_pulse_a: assert property ( // [RULE9] [RULE10]
    flux_seen_s ##0 stay_sel_s |=> raw_cnt_q == RAW_CYC - 1 && !raw_data_n_o)
    else $error("flux pulse missing or wrong width");
  sep_off_a: assert property ( // [RULE11]
    !$past(sep_en) |-> separated_data_pulse_n_o && separated_clock_pulse_n_o)
    else $error("separated outputs driven without option");
  two_sided_a: assert property ( // [RULE14] [RULE15]
    !two_sided_n_o |-> $past(head_load_command && s2_q[P_DSM] && ds_en))
    else $error("double sided flag with heads unloaded or single media");
  side_excl_a: assert property ( // [RULE16]
    !(ill_en && ds_en))
    else $error("both side flag options enabled");
endmodule
`default_nettype wire

// ==== shared/dds_pkg.sv ====
// package of constants for the disk drive status output block
`default_nettype none
package dds_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ          = 200;
  localparam int READY_S          = 2;
  localparam int READY_CYC        = READY_S * 1000000 * CLK_MHZ;
  localparam int INDEX_LONG_US10  = 17;   // 1.7 ms in tenths of a ms
  localparam int INDEX_LONG_CYC   = INDEX_LONG_US10 * 100 * CLK_MHZ;
  localparam int INDEX_SHORT_US   = 400;
  localparam int INDEX_SHORT_CYC  = INDEX_SHORT_US * CLK_MHZ;
  localparam int SECTOR_US        = 400;
  localparam int SECTOR_CYC       = SECTOR_US * CLK_MHZ;
  localparam int RAW_NS           = 200;
  localparam int RAW_CYC          = RAW_NS * CLK_MHZ / 1000;
  localparam int SEP_NS           = 200;
  localparam int SEP_CYC          = SEP_NS * CLK_MHZ / 1000;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0]  ADR_CTRL  = 4'h0;
  localparam logic [3:0]  ADR_STAT  = 4'h4;
  localparam logic [31:0] CTRL_RST  = 32'h0;
  localparam int CB_HARD = 0;
  localparam int CB_DIV  = 1;   // two bits
  localparam int CB_SEP  = 3;
  localparam int CB_ILL  = 4;
  localparam int CB_DS   = 5;
  localparam int CB_BIN  = 6;
  localparam int CB_RAD  = 7;
  localparam int CB_UNIT = 8;   // three bits
  // ------------------------------------------------------------
  // pin input vector positions
  // ------------------------------------------------------------
  localparam int NIN   = 17;
  localparam int P_PWR = 4;
  localparam int P_SPD = 5;
  localparam int P_MED = 6;
  localparam int P_PRT = 7;
  localparam int P_TRK = 8;
  localparam int P_IDX = 9;
  localparam int P_SEC = 10;
  localparam int P_FLX = 11;
  localparam int P_DTR = 12;
  localparam int P_CTR = 13;
  localparam int P_DSM = 14;
  localparam int P_SD1 = 15;
  localparam int P_HLD = 16;
  localparam logic [NIN-1:0] SYNC_RST = 17'h1800f;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DIV32 = 2'b00,
    DIV16 = 2'b01,
    DIV8  = 2'b10
  } dds_div_t;
  typedef enum logic [1:0] {
    RDY_OFF  = 2'b00,
    RDY_WAIT = 2'b01,
    RDY_ON   = 2'b10
  } dds_rdy_t;
endpackage
`default_nettype wire
